/* File: vrpart_top.sv */
`timescale 1ns/100ps
`include "vrpart_defs.svh"

// Operation
// - Physical pool shared, allocated on demand
// - Each context owns its own control registers
// - Table keeps owner context and index
// - Physical assignment never visible to software
// - Map write grabs free physical register
// - Successful map sets matching access bit
// - Pool exhausted leaves access mask unchanged
// - Blocked instruction sets request bits, excepts
// - Save set or access clear blocks
// - Register writes set modify bits
// - Intra-context switching through save bits only
// - Unmap write frees backing physical register
// - Freed register serves any context, index
// - Mapped index resolves to same storage
// - Reset clears all four masks everywhere
module vrpart_top (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  // Avalon-MM slave
  input  wire logic [`VRPART_ADDR_W-1:0]    avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [3:0]                   avs_byteenable,
  input  wire logic [31:0]                  avs_writedata,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  // Vector instruction check from the issue stage
  input  wire logic                         vi_valid,
  input  wire logic [`VRPART_CTX_W-1:0]     vi_ctx,
  input  wire logic [`VRPART_ARCH_N-1:0]    vi_use_mask,
  input  wire logic [`VRPART_ARCH_N-1:0]    vi_write_mask,
  output logic                              vi_exception,
  // Register resolve for the datapath
  input  wire logic [`VRPART_CTX_W-1:0]     rs_ctx,
  input  wire logic [`VRPART_ARCH_W-1:0]    rs_idx,
  output logic [`VRPART_PHYS_W-1:0]         rs_phys,
  output logic                              rs_hit
);

  localparam vrpart_pkg::vrpart_state_t RST_STATE = '{
    waitrequest : 1'b1,
    default     : '0
  };

  vrpart_pkg::vrpart_state_t st;
  vrpart_pkg::vrpart_state_t next_st;

  // Decoded bus fields
  vrpart_pkg::vrpart_ctx_t   bus_ctx;
  logic [2:0]                bus_sel;
  vrpart_pkg::vrpart_aidx_t  bus_idx;
  logic [31:0]               bus_bm;
  logic                      bus_go;
  logic                      map_go;
  logic                      unmap_go;

  // Search results over the physical table
  logic [`VRPART_PHYS_N-1:0] own_hit;
  logic [`VRPART_PHYS_N-1:0] rs_match;
  logic                      own_any;
  vrpart_pkg::vrpart_pidx_t  own_idx;
  logic                      free_any;
  vrpart_pkg::vrpart_pidx_t  free_idx;
  vrpart_pkg::vrpart_pidx_t  rs_enc;
  logic                      vi_blocked;

  assign bus_ctx  = avs_address[`VRPART_ADDR_W-1:`VRPART_CTX_LSB];
  assign bus_sel  = avs_address[`VRPART_CTX_LSB-1:`VRPART_SEL_LSB];
  assign bus_idx  = avs_writedata[`VRPART_ARCH_W-1:0];
  assign bus_bm   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // A write takes effect only in the cycle waitrequest is low
  assign bus_go   = avs_write && !st.waitrequest;
  assign map_go   = bus_go && avs_byteenable[0] &&
                    (bus_sel == `VRPART_SEL_MAP);
  assign unmap_go = bus_go && avs_byteenable[0] &&
                    (bus_sel == `VRPART_SEL_UNMAP);

  // Per-entry match against the writer's and the resolve port's context and index
  genvar g;
  generate
    for (g = 0; g < `VRPART_PHYS_N; g++) begin : g_entry
      assign own_hit[g]  = st.tbl_valid[g] && (st.tbl_ctx[g] == bus_ctx) &&
                           (st.tbl_idx[g] == bus_idx);
      assign rs_match[g] = st.tbl_valid[g] && (st.tbl_ctx[g] == rs_ctx) &&
                           (st.tbl_idx[g] == rs_idx);
    end
  endgenerate

  // Encoders; lowest free entry wins, any context may take it
  always_comb begin
    own_any  = 1'b0;
    own_idx  = '0;
    free_any = 1'b0;
    free_idx = '0;
    rs_enc   = '0;
    for (int i = `VRPART_PHYS_N - 1; i >= 0; i--) begin
      if (!st.tbl_valid[i]) begin
        free_any = 1'b1;
        free_idx = i[`VRPART_PHYS_W-1:0];
      end
      if (own_hit[i]) begin
        own_any = 1'b1;
        own_idx = i[`VRPART_PHYS_W-1:0];
      end
      if (rs_match[i]) begin
        rs_enc = i[`VRPART_PHYS_W-1:0];
      end
    end
  end

  assign vi_blocked = vi_valid &&
                      ((vi_use_mask & (st.save[vi_ctx] | ~st.access[vi_ctx]))
                       != '0);

  // Next-state logic; hardware sets are applied last so they win
  always_comb begin
    next_st = st;
    next_st.vi_exception = 1'b0;
    // One wait cycle per access gives time to stage read data
    next_st.waitrequest = !((avs_read || avs_write) && st.waitrequest);

    if (avs_read && st.waitrequest) begin
      case (bus_sel)
        `VRPART_SEL_ACCESS:  next_st.readdata = st.access[bus_ctx];
        `VRPART_SEL_SAVE:    next_st.readdata = st.save[bus_ctx];
        `VRPART_SEL_REQUEST: next_st.readdata = st.request[bus_ctx];
        `VRPART_SEL_MODIFY:  next_st.readdata = st.modify[bus_ctx];
        default:             next_st.readdata = 32'h00000000;
      endcase
    end

    if (bus_go) begin
      case (bus_sel)
        `VRPART_SEL_SAVE: begin
          next_st.save[bus_ctx] = (st.save[bus_ctx] & ~bus_bm) |
                                  (avs_writedata & bus_bm);
        end
        `VRPART_SEL_REQUEST: begin
          next_st.request[bus_ctx] = (st.request[bus_ctx] & ~bus_bm) |
                                     (avs_writedata & bus_bm);
        end
        `VRPART_SEL_MODIFY: begin
          next_st.modify[bus_ctx] = (st.modify[bus_ctx] & ~bus_bm) |
                                    (avs_writedata & bus_bm);
        end
        default: begin
        end
      endcase
    end

    if (map_go && !st.access[bus_ctx][bus_idx] && free_any) begin
      next_st.tbl_valid[free_idx] = 1'b1;
      next_st.tbl_ctx[free_idx]   = bus_ctx;
      next_st.tbl_idx[free_idx]   = bus_idx;
      next_st.access[bus_ctx][bus_idx] = 1'b1;
    end

    if (unmap_go && own_any) begin
      next_st.tbl_valid[own_idx] = 1'b0;
      next_st.access[bus_ctx][bus_idx] = 1'b0;
    end

    if (vi_blocked) begin
      next_st.request[vi_ctx] = next_st.request[vi_ctx] | vi_use_mask;
      next_st.vi_exception    = 1'b1;
    end else if (vi_valid) begin
      next_st.modify[vi_ctx] = next_st.modify[vi_ctx] | vi_write_mask;
    end

    next_st.rs_hit  = |rs_match;
    next_st.rs_phys = rs_enc;
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state flops
  assign avs_readdata    = st.readdata;
  assign avs_waitrequest = st.waitrequest;
  assign vi_exception    = st.vi_exception;
  assign rs_phys         = st.rs_phys;
  assign rs_hit          = st.rs_hit;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  property p_map_sets;
    map_go && !st.access[bus_ctx][bus_idx] && free_any |=>
      st.access[$past(bus_ctx)][$past(bus_idx)] &&
      st.tbl_valid[$past(free_idx)];
  endproperty
  a_map_sets: assert property (p_map_sets)
    else $error("Map did not set access bit");

  property p_map_full;
    map_go && !free_any && !unmap_go |=> $stable(st.access) &&
      $stable(st.tbl_valid);
  endproperty
  a_map_full: assert property (p_map_full)
    else $error("Map with full pool changed state");

  property p_map_dup;
    map_go && st.access[bus_ctx][bus_idx] |=> $stable(st.tbl_valid);
  endproperty
  a_map_dup: assert property (p_map_dup)
    else $error("Duplicate map consumed an entry");

  property p_unmap_none;
    unmap_go && !own_any |=> $stable(st.tbl_valid) && $stable(st.access);
  endproperty
  a_unmap_none: assert property (p_unmap_none)
    else $error("Unmap of unmapped index had effect");

  property p_unmap_free;
    unmap_go && own_any |=> !st.tbl_valid[$past(own_idx)] &&
      !st.access[$past(bus_ctx)][$past(bus_idx)];
  endproperty
  a_unmap_free: assert property (p_unmap_free)
    else $error("Unmap did not free entry and access bit");

  property p_block;
    vi_blocked |=> vi_exception &&
      ((st.request[$past(vi_ctx)] & $past(vi_use_mask)) ==
       $past(vi_use_mask));
  endproperty
  a_block: assert property (p_block)
    else $error("Blocked instruction missed request or exception");

  property p_no_block;
    vi_valid && !vi_blocked |=> !vi_exception &&
      ((st.modify[$past(vi_ctx)] & $past(vi_write_mask)) ==
       $past(vi_write_mask));
  endproperty
  a_no_block: assert property (p_no_block)
    else $error("Allowed write did not set modify bits");

  property p_resolve;
    ##1 $stable(st.tbl_valid) && $stable(rs_ctx) && $stable(rs_idx) &&
      $past(rs_hit) |=> $stable(rs_phys);
  endproperty
  a_resolve: assert property (p_resolve)
    else $error("Mapped register resolved to new storage");

  property p_bus_answer;
    (avs_read || avs_write) && st.waitrequest |=> !avs_waitrequest ##1
      avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Bus answer not one cycle after request");

  property p_reset;
    disable iff (1'b0)
    !reset_n |=> st.access == '0 && st.save == '0 &&
      st.request == '0 && st.modify == '0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("Masks not cleared by reset");

  c_map_ok: cover property (map_go && free_any &&
                            !st.access[bus_ctx][bus_idx]);
  c_map_full: cover property (map_go && !free_any);
  c_unmap_ok: cover property (unmap_go && own_any);
  c_blocked: cover property (vi_blocked);

endmodule : vrpart_top

/* File: vrpart_defs.svh */
`ifndef VRPART_DEFS_SVH
`define VRPART_DEFS_SVH

// Pool dimensions
`define VRPART_CTX_N        4
`define VRPART_PHYS_N       64
`define VRPART_ARCH_N       32
`define VRPART_CTX_W        2
`define VRPART_PHYS_W       6
`define VRPART_ARCH_W       5

// Avalon byte address layout: context in [6:5], register in [4:2]
`define VRPART_ADDR_W       7
`define VRPART_CTX_LSB      5
`define VRPART_SEL_LSB      2

// Register selects inside one context window (byte offset = sel * 4)
`define VRPART_SEL_MAP      3'h0
`define VRPART_SEL_UNMAP    3'h1
`define VRPART_SEL_ACCESS   3'h2
`define VRPART_SEL_SAVE     3'h3
`define VRPART_SEL_REQUEST  3'h4
`define VRPART_SEL_MODIFY   3'h5

// Reset values of the per-context masks
`define VRPART_MASK_RESET   32'h00000000

`endif

/* File: vrpart_pkg.sv */
`include "vrpart_defs.svh"

package vrpart_pkg;

  typedef logic [`VRPART_ARCH_N-1:0] vrpart_mask_t;
  typedef logic [`VRPART_CTX_W-1:0]  vrpart_ctx_t;
  typedef logic [`VRPART_ARCH_W-1:0] vrpart_aidx_t;
  typedef logic [`VRPART_PHYS_W-1:0] vrpart_pidx_t;

  // Complete state of the partitioning block
  typedef struct packed {
    logic [`VRPART_PHYS_N-1:0]                     tbl_valid;
    logic [`VRPART_PHYS_N-1:0][`VRPART_CTX_W-1:0]  tbl_ctx;
    logic [`VRPART_PHYS_N-1:0][`VRPART_ARCH_W-1:0] tbl_idx;
    logic [`VRPART_CTX_N-1:0][`VRPART_ARCH_N-1:0]  access;
    logic [`VRPART_CTX_N-1:0][`VRPART_ARCH_N-1:0]  save;
    logic [`VRPART_CTX_N-1:0][`VRPART_ARCH_N-1:0]  request;
    logic [`VRPART_CTX_N-1:0][`VRPART_ARCH_N-1:0]  modify;
    logic                                          waitrequest;
    logic [31:0]                                   readdata;
    logic                                          vi_exception;
    logic [`VRPART_PHYS_W-1:0]                     rs_phys;
    logic                                          rs_hit;
  } vrpart_state_t;

endpackage : vrpart_pkg

/* File: vrpart_top_tb.sv */
`timescale 1ns/100ps
`include "vrpart_defs.svh"

module vrpart_top_tb;
  // Bench drive and observe signals
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [6:0]  avs_address = 7'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        vi_valid = 1'b0;
  logic [1:0]  vi_ctx = 2'h0;
  logic [31:0] vi_use_mask = 32'h00000000;
  logic [31:0] vi_write_mask = 32'h00000000;
  logic        vi_exception;
  logic [1:0]  rs_ctx = 2'h0;
  logic [4:0]  rs_idx = 5'h00;
  logic [5:0]  rs_phys;
  logic        rs_hit;
  logic        rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] rnd;
  integer      seed = 32'h814459E6;
  int          failures = 0;
  int          total_checks = 0;

  // Free-running 50 MHz clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  vrpart_top i_dut (
    .ref_clk         (ref_clk),
    .reset_n         (reset_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .vi_valid        (vi_valid),
    .vi_ctx          (vi_ctx),
    .vi_use_mask     (vi_use_mask),
    .vi_write_mask   (vi_write_mask),
    .vi_exception    (vi_exception),
    .rs_ctx          (rs_ctx),
    .rs_idx          (rs_idx),
    .rs_phys         (rs_phys),
    .rs_hit          (rs_hit)
  );

  task automatic conclude();
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One Avalon access; request held until waitrequest sampled low
  task automatic bus(input logic [1:0] c, input logic [2:0] s,
                     input logic rd, input logic [3:0] be,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_address <= {c, s, 2'b00};
    avs_read <= rd;
    avs_write <= ~rd;
    rd_pend <= rd;
    avs_byteenable <= be;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) failures++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    rd_pend <= 1'b0;
  endtask : bus

  task automatic wr(input logic [1:0] c, input logic [2:0] s,
                    input logic [31:0] d);
    bus(c, s, 1'b0, 4'hF, d);
  endtask : wr

  // Expected read value noted before the request goes out
  task automatic rd(input logic [1:0] c, input logic [2:0] s,
                    input logic [31:0] e);
    exp_q.push_back(e);
    bus(c, s, 1'b1, 4'hF, 32'h00000000);
  endtask : rd

  // Read results are matched against the oldest note
  always @(posedge ref_clk) begin
    if (rd_pend && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      chk(avs_readdata, exp_q.pop_front());
    end
  end

  task automatic vchk(input logic [1:0] c, input logic [31:0] u,
                      input logic [31:0] w, input logic e);
    @(posedge ref_clk);
    vi_valid <= 1'b1;
    vi_ctx <= c;
    vi_use_mask <= u;
    vi_write_mask <= w;
    @(posedge ref_clk);
    vi_valid <= 1'b0;
    #1 chk({31'h0, vi_exception}, {31'h0, e});
  endtask : vchk

  task automatic rchk(input logic [1:0] c, input logic [4:0] i,
                      input logic h, input logic [5:0] p);
    @(posedge ref_clk);
    rs_ctx <= c;
    rs_idx <= i;
    @(posedge ref_clk);
    #1 chk({25'h0, rs_hit, rs_phys}, {25'h0, h, p});
  endtask : rchk

  task automatic do_reset();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask : do_reset

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    conclude();
  end

  initial begin
    do_reset();
    // Every select of every context reads zero after reset
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 8; s++) begin
        rd(2'(c), 3'(s), 32'h00000000);
      end
    end
    wr(0, `VRPART_SEL_MAP, 32'h00000002);
    rd(0, `VRPART_SEL_ACCESS, 32'h00000004);
    wr(0, `VRPART_SEL_MAP, 32'h00000001);
    rd(0, `VRPART_SEL_ACCESS, 32'h00000006);
    // Duplicate map, lane 0 off, read-only and unused writes
    wr(0, `VRPART_SEL_MAP, 32'h00000002);
    bus(0, `VRPART_SEL_MAP, 1'b0, 4'hE, 32'h00000003);
    wr(0, `VRPART_SEL_ACCESS, 32'hFFFFFFFF);
    wr(1, 3'h6, 32'hFFFFFFFF);
    rd(0, `VRPART_SEL_ACCESS, 32'h00000006);
    rd(1, 3'h6, 32'h00000000);
    rd(3, `VRPART_SEL_ACCESS, 32'h00000000);
    rchk(0, 5'h01, 1'b1, 6'h01);
    rchk(0, 5'h02, 1'b1, 6'h00);
    // Independent RW masks per context
    for (int c = 0; c < 4; c++) begin
      for (int s = 3; s < 6; s++) begin
        rnd = $random(seed);
        wr(2'(c), 3'(s), rnd);
        rd(2'(c), 3'(s), rnd);
        wr(2'(c), 3'(s), 32'h00000000);
      end
    end
    vchk(0, 32'h00000002, 32'h00000002, 1'b0);
    rd(0, `VRPART_SEL_MODIFY, 32'h00000002);
    wr(0, `VRPART_SEL_SAVE, 32'h00000004);
    vchk(0, 32'h00000006, 32'h00000004, 1'b1);
    rd(0, `VRPART_SEL_REQUEST, 32'h00000006);
    rd(0, `VRPART_SEL_MODIFY, 32'h00000002);
    rnd = $random(seed) | 32'h00000008;
    vchk(0, rnd, rnd & 32'h00000008, 1'b1);
    rd(0, `VRPART_SEL_REQUEST, rnd | 32'h00000006);
    wr(0, `VRPART_SEL_UNMAP, 32'h00000005);
    rd(0, `VRPART_SEL_ACCESS, 32'h00000006);
    wr(0, `VRPART_SEL_UNMAP, 32'h00000001);
    rd(0, `VRPART_SEL_ACCESS, 32'h00000004);
    rchk(0, 5'h01, 1'b0, 6'h00);
    // Second reset in mid-run, then fill the whole pool
    do_reset();
    rd(0, `VRPART_SEL_ACCESS, 32'h00000000);
    rd(0, `VRPART_SEL_REQUEST, 32'h00000000);
    for (int i = 0; i < 64; i++) begin
      wr(2'(i / 32), `VRPART_SEL_MAP, 32'(i % 32));
    end
    rd(0, `VRPART_SEL_ACCESS, 32'hFFFFFFFF);
    rd(1, `VRPART_SEL_ACCESS, 32'hFFFFFFFF);
    rchk(1, 5'h05, 1'b1, 6'h25);
    wr(2, `VRPART_SEL_MAP, 32'h00000009);
    rd(2, `VRPART_SEL_ACCESS, 32'h00000000);
    // Freed entry reused by another context and index
    wr(0, `VRPART_SEL_UNMAP, 32'h00000007);
    wr(2, `VRPART_SEL_MAP, 32'h00000009);
    rd(2, `VRPART_SEL_ACCESS, 32'h00000200);
    rchk(2, 5'h09, 1'b1, 6'h07);
    rchk(0, 5'h07, 1'b0, 6'h00);
    // Lazy switch on context 1, then its register 0 handed to context 3
    wr(1, `VRPART_SEL_SAVE, 32'hFFFFFFFF);
    vchk(1, 32'h00000001, 32'h00000001, 1'b1);
    wr(1, `VRPART_SEL_SAVE, 32'hFFFFFFFE);
    vchk(1, 32'h00000001, 32'h00000001, 1'b0);
    rd(1, `VRPART_SEL_MODIFY, 32'h00000001);
    wr(1, `VRPART_SEL_UNMAP, 32'h00000000);
    wr(3, `VRPART_SEL_MAP, 32'h00000005);
    rd(3, `VRPART_SEL_ACCESS, 32'h00000020);
    vchk(3, 32'h00000020, 32'h00000020, 1'b0);
    wr(3, `VRPART_SEL_MODIFY, 32'h00000000);
    rd(3, `VRPART_SEL_MODIFY, 32'h00000000);
    rchk(3, 5'h05, 1'b1, 6'h20);
    conclude();
  end
endmodule : vrpart_top_tb
